//--- pkg/etoc_defines.vh
// etoc_defines.vh: offsets, field positions, reset values and codes of the
// extended timer output-compare block.
// assumes a single 125 MHz core clock and a plain strobe register port.
//
// Overview of operation
// [R1] two-bit action field picks set, clear, toggle or hold on compare match
// [R2] a configuration bit gives the compare pin level before any match
// [R3] initial level changes only when written together with its write-enable bit set
// [R4] software writes the compare value low byte first, then high byte
// [R5] low byte is staged; both bytes commit together on the high byte write
// [R6] software never updates the compare value by a low byte write alone
// [R7] counter equal to compare value applies the action and raises compare request
// [R8] hold action leaves the pin alone and only raises the compare request
// [R9] action code 11 inverts the present pin level on every match
// [R10] while the run bit is zero the compare pin is held high
// [R11] three separate requests: counter overflow, capture done, compare match
// [R12] overflow request when the counter reaches all ones; counting goes on
// [R13] capture request when the sampled count is written to the capture register
// [R14] software sets the shared pin latch to one before making it an output
// [R15] action codes: 00 hold, 01 drive high, 10 drive low, 11 toggle
// [R16] compare register and comparison are sixteen bits, like the counter
`ifndef ETOC_DEFINES_VH
`define ETOC_DEFINES_VH

// register port geometry
`define ETOC_ADDR_W        3
`define ETOC_DATA_W        8
`define ETOC_CNT_W         16

// register offsets
`define ETOC_OFS_MODE      3'h0
`define ETOC_OFS_CTRL      3'h1
`define ETOC_OFS_CMP_LO    3'h2
`define ETOC_OFS_CMP_HI    3'h3
`define ETOC_OFS_IRQ_STAT  3'h4
`define ETOC_OFS_IRQ_MASK  3'h5
`define ETOC_OFS_PIN_STAT  3'h6

// mode register fields
`define ETOC_MODE_ACT_LSB  0
`define ETOC_MODE_ACT_MSB  1
`define ETOC_MODE_INIT_BIT 2
`define ETOC_MODE_WREN_BIT 7

// control register fields
`define ETOC_CTRL_RUN_BIT  0

// interrupt bit positions
`define ETOC_IRQ_OVF       0
`define ETOC_IRQ_CAP       1
`define ETOC_IRQ_CMP       2
`define ETOC_IRQ_N         3

// match action codes
`define ETOC_ACT_HOLD      2'h0
`define ETOC_ACT_HIGH      2'h1
`define ETOC_ACT_LOW       2'h2
`define ETOC_ACT_TOGGLE    2'h3

// reset values
`define ETOC_RST_ACT       2'h0
`define ETOC_RST_INIT      1'h0
`define ETOC_RST_WREN      1'h0
`define ETOC_RST_RUN       1'h0
`define ETOC_RST_CMP       16'h0000
`define ETOC_RST_MASK      3'h0
`define ETOC_CNT_ALL_ONES  16'hFFFF
`define ETOC_DATA_ZERO     8'h00

`endif

//--- rtl/etoc_irq.v
// etoc_irq.v: sticky interrupt status, mask and one level request.
// assumes events are single-cycle pulses on core_clk_i and that a read
// strobe of the status register clears it.
`include "etoc_defines.vh"

module etoc_irq (
  input  wire                    core_clk_i,
  input  wire                    rst_b_i,
  input  wire [`ETOC_IRQ_N-1:0]  event_i,
  input  wire                    status_rd_i,
  input  wire                    mask_wr_i,
  input  wire [`ETOC_IRQ_N-1:0]  mask_wdata_i,
  output reg  [`ETOC_IRQ_N-1:0]  status_o,
  output reg  [`ETOC_IRQ_N-1:0]  mask_o,
  output reg                     irq_o
);

  genvar gi;

  // one sticky flag per event; a set in the clearing cycle wins so no event is lost
  generate
    for (gi = 0; gi < `ETOC_IRQ_N; gi = gi + 1) begin : g_flag
      always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          status_o[gi] <= 1'b0;
        end else if (event_i[gi]) begin
          status_o[gi] <= 1'b1;
        end else if (status_rd_i) begin
          status_o[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // mask register: a one lets the status bit through
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_o <= `ETOC_RST_MASK;
    end else if (mask_wr_i) begin
      mask_o <= mask_wdata_i;
    end
  end

  // level request follows the flags one cycle late so the output is a flop
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_o & mask_o);
    end
  end

endmodule

//--- rtl/etoc_top.v
// etoc_top.v: output-compare and interrupt-request logic of a 16-bit
// extended timer-counter.
// assumes the counter, its prescaler and the capture datapath sit outside
// on the same core_clk_i; counter value and capture strobe need no sync.
`include "etoc_defines.vh"

module etoc_top (
  input  wire                    core_clk_i,
  input  wire                    rst_b_i,
  // register port
  input  wire [`ETOC_ADDR_W-1:0] reg_addr_i,
  input  wire [`ETOC_DATA_W-1:0] reg_wdata_i,
  input  wire                    reg_wr_i,
  input  wire                    reg_rd_i,
  output reg  [`ETOC_DATA_W-1:0] reg_rdata_o,
  // counter side
  input  wire [`ETOC_CNT_W-1:0]  extended_counter_i,
  input  wire                    capture_load_i,
  output reg                     counter_run_bit_o,
  // pin and requests
  output reg                     compare_output_pin_o,
  output reg                     counter_overflow_irq_o,
  output reg                     capture_done_irq_o,
  output reg                     compare_match_irq_o,
  output reg                     irq_o
);

  // mode register fields
  reg  [1:0]                match_action_select;
  reg                       initial_output_level;
  reg                       initial_level_write_enable;

  // control register
  reg                       counter_run_bit;

  // compare value: staged low byte and active 16-bit value
  reg  [`ETOC_DATA_W-1:0]   compare_lo_stage;
  reg  [`ETOC_CNT_W-1:0]    compare_value_reg;

  // internal pin state kept while the counter is stopped
  reg                       oc_level;
  reg                       next_oc_level;

  // match and overflow edge detection
  reg                       match_prev;
  reg                       ovf_prev;
  wire                      match_now;
  wire                      ovf_now;
  wire                      match_evt;
  wire                      ovf_evt;
  wire                      cap_evt;

  // decoded strobes
  wire                      wr_mode;
  wire                      wr_ctrl;
  wire                      wr_cmp_lo;
  wire                      wr_cmp_hi;
  wire                      wr_mask;
  wire                      rd_stat;

  // interrupt block
  wire [`ETOC_IRQ_N-1:0]    irq_events;
  wire [`ETOC_IRQ_N-1:0]    irq_status;
  wire [`ETOC_IRQ_N-1:0]    irq_mask;
  wire                      irq_level;

  reg  [`ETOC_DATA_W-1:0]   next_rdata;

  // write and read decode
  assign wr_mode   = reg_wr_i && (reg_addr_i == `ETOC_OFS_MODE);
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == `ETOC_OFS_CTRL);
  assign wr_cmp_lo = reg_wr_i && (reg_addr_i == `ETOC_OFS_CMP_LO);
  assign wr_cmp_hi = reg_wr_i && (reg_addr_i == `ETOC_OFS_CMP_HI);
  assign wr_mask   = reg_wr_i && (reg_addr_i == `ETOC_OFS_IRQ_MASK);
  assign rd_stat   = reg_rd_i && (reg_addr_i == `ETOC_OFS_IRQ_STAT);

  // mode register: action field always writable
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_action_select        <= `ETOC_RST_ACT;
      initial_level_write_enable <= `ETOC_RST_WREN;
    end else if (wr_mode) begin
      match_action_select        <= reg_wdata_i[`ETOC_MODE_ACT_MSB:`ETOC_MODE_ACT_LSB]; // [R1]
      initial_level_write_enable <= reg_wdata_i[`ETOC_MODE_WREN_BIT];
    end
  end

  // initial level bit: the enable in the same write gates it, so one write
  // can both set the level and open the gate; a later write with the
  // enable clear leaves the level as it was
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      initial_output_level <= `ETOC_RST_INIT;
    end else if (wr_mode && reg_wdata_i[`ETOC_MODE_WREN_BIT]) begin
      initial_output_level <= reg_wdata_i[`ETOC_MODE_INIT_BIT]; // [R2] [R3]
    end
  end

  // control register: run bit also drives the external counter
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_run_bit <= `ETOC_RST_RUN;
    end else if (wr_ctrl) begin
      counter_run_bit <= reg_wdata_i[`ETOC_CTRL_RUN_BIT];
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_run_bit_o <= `ETOC_RST_RUN;
    end else begin
      counter_run_bit_o <= counter_run_bit;
    end
  end

  // low byte waits in a stage; it never reaches the comparator alone,
  // so a half-written value can not produce a stray match
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_lo_stage <= `ETOC_DATA_ZERO;
    end else if (wr_cmp_lo) begin
      compare_lo_stage <= reg_wdata_i; // [R5]
    end
  end

  // high byte write commits both bytes at once; a low write that is
  // never followed by a high write has no effect on the comparator
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_value_reg <= `ETOC_RST_CMP;
    end else if (wr_cmp_hi) begin
      compare_value_reg <= {reg_wdata_i, compare_lo_stage}; // [R5] [R6]
    end
  end

  // full-width equality, same width as the counter
  assign match_now = (extended_counter_i == compare_value_reg); // [R16]

  // overflow point of the free-running counter
  assign ovf_now = (extended_counter_i == `ETOC_CNT_ALL_ONES);

  // events fire on entry into the condition: the counter may dwell on one
  // value for many clocks under a slow prescale, and one dwell is one event
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_prev <= 1'b0;
      ovf_prev   <= 1'b0;
    end else begin
      match_prev <= match_now && counter_run_bit;
      ovf_prev   <= ovf_now && counter_run_bit;
    end
  end

  // a stopped counter produces no match or overflow events
  assign match_evt = match_now && counter_run_bit && !match_prev; // [R7]
  assign ovf_evt   = ovf_now && counter_run_bit && !ovf_prev;     // [R12]
  assign cap_evt   = capture_load_i;                              // [R13]

  // next pin level from the selected action
  always @* begin
    next_oc_level = oc_level;
    if (wr_mode && reg_wdata_i[`ETOC_MODE_WREN_BIT]) begin
      next_oc_level = reg_wdata_i[`ETOC_MODE_INIT_BIT]; // [R2] [R3]
    end else if (match_evt) begin
      case (match_action_select) // [R15]
        `ETOC_ACT_HOLD: begin
          next_oc_level = oc_level; // [R8]
        end
        `ETOC_ACT_HIGH: begin
          next_oc_level = 1'b1; // [R1]
        end
        `ETOC_ACT_LOW: begin
          next_oc_level = 1'b0; // [R1]
        end
        `ETOC_ACT_TOGGLE: begin
          next_oc_level = ~oc_level; // [R9]
        end
        default: begin
          next_oc_level = oc_level;
        end
      endcase
    end
  end

  // internal level keeps its value across a stop so a restart resumes it
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oc_level <= `ETOC_RST_INIT;
    end else begin
      oc_level <= next_oc_level; // [R7]
    end
  end

  // pin: forced high while stopped, otherwise the compare level; it loads the same
  // next level as the internal level on the same clock, so the output comes from a flop
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_output_pin_o <= 1'b1;
    end else if (!counter_run_bit) begin
      compare_output_pin_o <= 1'b1; // [R10]
    end else begin
      compare_output_pin_o <= next_oc_level;
    end
  end

  // three separate one-cycle request pulses
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_overflow_irq_o <= 1'b0;
      capture_done_irq_o     <= 1'b0;
      compare_match_irq_o    <= 1'b0;
    end else begin
      counter_overflow_irq_o <= ovf_evt;   // [R11] [R12]
      capture_done_irq_o     <= cap_evt;   // [R11] [R13]
      compare_match_irq_o    <= match_evt; // [R11] [R7] [R8]
    end
  end

  // event vector for the sticky status
  assign irq_events[`ETOC_IRQ_OVF] = ovf_evt;
  assign irq_events[`ETOC_IRQ_CAP] = cap_evt;
  assign irq_events[`ETOC_IRQ_CMP] = match_evt;

  // sticky status, mask and level request
  etoc_irq u_irq (
    .core_clk_i   (core_clk_i),
    .rst_b_i      (rst_b_i),
    .event_i      (irq_events),
    .status_rd_i  (rd_stat),
    .mask_wr_i    (wr_mask),
    .mask_wdata_i (reg_wdata_i[`ETOC_IRQ_N-1:0]),
    .status_o     (irq_status),
    .mask_o       (irq_mask),
    .irq_o        (irq_level)
  );

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_level;
    end
  end

  // read mux; unmapped offsets and reserved bits read as zero
  always @* begin
    next_rdata = `ETOC_DATA_ZERO;
    case (reg_addr_i)
      `ETOC_OFS_MODE: begin
        next_rdata[`ETOC_MODE_ACT_MSB:`ETOC_MODE_ACT_LSB] = match_action_select;
        next_rdata[`ETOC_MODE_INIT_BIT]                   = initial_output_level;
        next_rdata[`ETOC_MODE_WREN_BIT]                   = initial_level_write_enable;
      end
      `ETOC_OFS_CTRL: begin
        next_rdata[`ETOC_CTRL_RUN_BIT] = counter_run_bit;
      end
      `ETOC_OFS_CMP_LO: begin
        next_rdata = compare_value_reg[7:0];
      end
      `ETOC_OFS_CMP_HI: begin
        next_rdata = compare_value_reg[15:8];
      end
      `ETOC_OFS_IRQ_STAT: begin
        next_rdata[`ETOC_IRQ_N-1:0] = irq_status;
      end
      `ETOC_OFS_IRQ_MASK: begin
        next_rdata[`ETOC_IRQ_N-1:0] = irq_mask;
      end
      `ETOC_OFS_PIN_STAT: begin
        next_rdata[0] = compare_output_pin_o;
        next_rdata[1] = oc_level;
      end
      default: begin
        next_rdata = `ETOC_DATA_ZERO;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `ETOC_DATA_ZERO;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= `ETOC_DATA_ZERO;
    end
  end

endmodule

//--- tb/etoc_cnt_model.sv
// etoc_cnt_model.sv: the free-running sixteen-bit counter beside the block.
// assumes the bench may preset it; counts only while the run output is high.
module etoc_cnt_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        run_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  output logic      [15:0] cnt_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // wraps past all ones and keeps counting, never stops on its own
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_o <= 16'h0000;
    end else if (load_i) begin
      cnt_o <= load_val_i;
    end else if (run_i) begin
      cnt_o <= cnt_o + 16'h0001;
    end
  end
endmodule

//--- tb/etoc_top_asserts.sv
// etoc_top_asserts.sv: port-level checks on compare pin and request outputs.
// assumes one core clock; mirrors mode and mask writes seen on the port.
`include "etoc_defines.vh"

module etoc_top_chk (
  input wire logic                    core_clk_i,
  input wire logic                    rst_b_i,
  input wire logic [`ETOC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`ETOC_DATA_W-1:0] reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [`ETOC_DATA_W-1:0] reg_rdata_o,
  input wire logic [`ETOC_CNT_W-1:0]  extended_counter_i,
  input wire logic                    capture_load_i,
  input wire logic                    counter_run_bit_o,
  input wire logic                    compare_output_pin_o,
  input wire logic                    counter_overflow_irq_o,
  input wire logic                    capture_done_irq_o,
  input wire logic                    compare_match_irq_o,
  input wire logic                    irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] act;
  logic [2:0] msk;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // shadow of action field and mask, so pin checks need no hierarchy peeks
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act <= `ETOC_RST_ACT;
      msk <= `ETOC_RST_MASK;
    end else if (reg_wr_i && reg_addr_i == `ETOC_OFS_MODE) begin
      act <= reg_wdata_i[1:0];
    end else if (reg_wr_i && reg_addr_i == `ETOC_OFS_IRQ_MASK) begin
      msk <= reg_wdata_i[2:0];
    end
  end

  // pin and run output both load from the same internal run flop, so they move together
  stop_high_a: assert property (!counter_run_bit_o |-> compare_output_pin_o)
    else $error("compare pin not high while stopped");
  set_high_a: assert property (compare_match_irq_o && act == `ETOC_ACT_HIGH && $past(counter_run_bit_o)
    |-> compare_output_pin_o)
    else $error("drive-high match left pin low");
  set_low_a: assert property (compare_match_irq_o && act == `ETOC_ACT_LOW && $past(counter_run_bit_o)
    |-> !compare_output_pin_o)
    else $error("drive-low match left pin high");
  toggle_pin_a: assert property (compare_match_irq_o && act == `ETOC_ACT_TOGGLE && $past(counter_run_bit_o)
    && $past(counter_run_bit_o, 2) && !$past(reg_wr_i) |-> compare_output_pin_o != $past(compare_output_pin_o))
    else $error("toggle match did not invert pin");
  hold_pin_a: assert property (compare_match_irq_o && act == `ETOC_ACT_HOLD && $past(counter_run_bit_o)
    && $past(counter_run_bit_o, 2) && !$past(reg_wr_i) |-> $stable(compare_output_pin_o))
    else $error("hold match moved the pin");
  ovf_source_a: assert property (counter_overflow_irq_o |-> $past(extended_counter_i) == `ETOC_CNT_ALL_ONES)
    else $error("overflow request without all-ones count");
  cap_pulse_a: assert property (capture_load_i |=> capture_done_irq_o ##1 !capture_done_irq_o)
    else $error("capture request missing or too long");
  irq_level_a: assert property ((|({compare_match_irq_o, capture_done_irq_o, counter_overflow_irq_o} & msk))
    && !reg_wr_i |=> ##1 irq_o)
    else $error("unmasked event gave no interrupt");

  cover property (compare_match_irq_o && act == `ETOC_ACT_TOGGLE);
  cover property (counter_overflow_irq_o);
  cover property (capture_done_irq_o);
endmodule

bind etoc_top etoc_top_chk u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .extended_counter_i(extended_counter_i),
  .capture_load_i(capture_load_i), .counter_run_bit_o(counter_run_bit_o),
  .compare_output_pin_o(compare_output_pin_o), .counter_overflow_irq_o(counter_overflow_irq_o),
  .capture_done_irq_o(capture_done_irq_o), .compare_match_irq_o(compare_match_irq_o), .irq_o(irq_o)
);

//--- tb/tb.sv
// tb.sv: self-checking bench for the output-compare block.
// assumes the counter model on the counter side and a strobe register master.
`include "etoc_defines.vh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [2:0]  reg_addr_i = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        capture_load_i = 1'b0;
  logic        ld_en = 1'b0;
  logic [15:0] ld_val = 16'h0000;
  logic [7:0]  reg_rdata_o;
  logic [15:0] cnt;
  logic        run, pin, ovf, cap, cmp, irq_o;
  int          fail_count = 0;
  int          tests_run = 0;

  always #4 core_clk_i = ~core_clk_i;

  etoc_cnt_model u_cnt (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .run_i(run), .load_i(ld_en),
    .load_val_i(ld_val), .cnt_o(cnt));
  etoc_top dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .extended_counter_i(cnt),
    .capture_load_i(capture_load_i), .counter_run_bit_o(run), .compare_output_pin_o(pin),
    .counter_overflow_irq_o(ovf), .capture_done_irq_o(cap), .compare_match_irq_o(cmp), .irq_o(irq_o));

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic ldcnt(input logic [15:0] v);
    @(posedge core_clk_i);
    ld_en <= 1'b1;
    ld_val <= v;
    @(posedge core_clk_i);
    ld_en <= 1'b0;
  endtask

  // reset values, read-only and unmapped places left untouched by writes
  task automatic t_reset;
    logic [7:0] d;
    chk("reset pin", pin, 1'b1);
    chk("reset run", run, 1'b0);
    wr(3'h7, 8'hFF);
    wr(`ETOC_OFS_IRQ_STAT, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk("reset reg", d, (a == 6) ? 8'h01 : 8'h00);
    end
    $display("test reset done");
  endtask

  // low byte is staged until the high byte commits both
  task automatic t_stage;
    logic [7:0] d;
    wr(`ETOC_OFS_IRQ_MASK, 8'h07);
    wr(`ETOC_OFS_CMP_LO, 8'h80);
    rd(`ETOC_OFS_CMP_LO, d);
    chk("staged low", d, 8'h00);
    wr(`ETOC_OFS_CMP_HI, 8'h0C);
    rd(`ETOC_OFS_CMP_LO, d);
    chk("active low", d, 8'h80);
    rd(`ETOC_OFS_CMP_HI, d);
    chk("active high", d, 8'h0C);
    $display("test stage done");
  endtask

  // every action code, gated level write, status read-clear and stop
  task automatic t_modes;
    logic [7:0] d;
    logic       init, e;
    for (int a = 0; a < 4; a++) begin
      init = (a == 2);
      e = (a == 0) ? init : (a == 1) ? 1'b1 : (a == 2) ? 1'b0 : ~init;
      wr(`ETOC_OFS_MODE, {1'b1, 4'h0, init, a[1:0]});
      ldcnt(16'h0C7A);
      wr(`ETOC_OFS_CTRL, 8'h01);
      repeat (2) @(posedge core_clk_i);
      #1 chk("start level", pin, init);
      for (int i = 0; i < 40 && cmp !== 1'b1; i++) begin
        @(posedge core_clk_i);
        #1;
      end
      chk("match pulse", cmp, 1'b1);
      chk("match pin", pin, e);
      // level request sits two flops behind the sticky status
      repeat (2) @(posedge core_clk_i);
      #1 chk("irq level", irq_o, 1'b1);
      wr(`ETOC_OFS_MODE, {1'b0, 4'h0, ~e, a[1:0]});
      rd(`ETOC_OFS_PIN_STAT, d);
      chk("gated level", d[1:0], {e, e});
      rd(`ETOC_OFS_IRQ_STAT, d);
      chk("cmp status", d, 8'h04);
      rd(`ETOC_OFS_IRQ_STAT, d);
      chk("status cleared", d, 8'h00);
      wr(`ETOC_OFS_CTRL, 8'h00);
      repeat (2) @(posedge core_clk_i);
      #1 chk("stopped pin", pin, 1'b1);
    end
    $display("test modes done");
  endtask

  // overflow keeps counting; masking drops the level but keeps status
  task automatic t_ovf;
    logic [7:0] d;
    ldcnt(16'hFFFC);
    wr(`ETOC_OFS_CTRL, 8'h01);
    for (int i = 0; i < 40 && ovf !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk("ovf pulse", ovf, 1'b1);
    chk("wrapped count", cnt, 16'h0000);
    chk("run output", run, 1'b1);
    wr(`ETOC_OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge core_clk_i);
    #1 chk("masked irq", irq_o, 1'b0);
    rd(`ETOC_OFS_IRQ_STAT, d);
    chk("ovf status", d, 8'h01);
    wr(`ETOC_OFS_IRQ_MASK, 8'h07);
    wr(`ETOC_OFS_CTRL, 8'h00);
    $display("test overflow done");
  endtask

  task automatic t_cap;
    logic [7:0] d;
    @(posedge core_clk_i);
    capture_load_i <= 1'b1;
    @(posedge core_clk_i);
    capture_load_i <= 1'b0;
    #1 chk("cap pulse", cap, 1'b1);
    rd(`ETOC_OFS_IRQ_STAT, d);
    chk("cap status", d, 8'h02);
    $display("test capture done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run is well under two thousand cycles
  initial begin
    #(8 * 5000);
    fail_count++;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    #1;
    t_reset;
    t_stage;
    t_modes;
    t_ovf;
    t_cap;
    finish_test;
  end
endmodule
